/* File: slp_pkg.sv */
/*
 * Shared constants, types and decode functions for the low-power state block.
 * Assumes a 100 MHz pclk; all pin timing is expressed in pclk cycles.
 */
package slp_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_REFI_NS     = 7800;
	localparam int CYC_REFI      = T_REFI_NS / CLK_PERIOD_NS;
	localparam int T_RFC_NS      = 260;
	localparam int CYC_RFC       = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_CPDED_NS    = 40;
	localparam int CYC_CPDED     = (T_CPDED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_REFCNT = 12'h008;
	localparam int          CTRL_ABORT_BIT  = 0;
	localparam int          CTRL_LPASR_LSB  = 1;
	localparam int          CTRL_ODTOFF_BIT = 3;
	localparam int          CTRL_PARK_BIT   = 4;
	localparam logic [4:0]  CTRL_RESET      = 5'h00;

	// ----------------------------------------
	// self-refresh modes and temperatures
	// ----------------------------------------
	localparam logic [1:0] LPASR_NORMAL   = 2'b00;
	localparam logic [1:0] LPASR_REDUCED  = 2'b01;
	localparam logic [1:0] LPASR_EXTENDED = 2'b10;
	localparam logic [1:0] LPASR_AUTO     = 2'b11;
	localparam logic [7:0] TEMP_REDUCED_MAX = 8'h2D;
	localparam logic [7:0] TEMP_NORMAL_MAX  = 8'h55;

	typedef enum logic [1:0] {RATE_LOW, RATE_NORM, RATE_HIGH} slp_rate_e;
	typedef enum logic [2:0] {ST_RESET, ST_IDLE, ST_SELF_REF, ST_PD_SETTLE, ST_PD_PRE, ST_PD_ACT} slp_state_e;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic slp_rate_e rate_for(input logic [1:0] mode, input logic [7:0] temp);
		slp_rate_e r;
		r = RATE_NORM;
		case (mode)
			LPASR_REDUCED:  r = RATE_LOW;
			LPASR_EXTENDED: r = RATE_HIGH;
			LPASR_AUTO:
			begin
				if (temp <= TEMP_REDUCED_MAX)
					r = RATE_LOW;
				else if (temp <= TEMP_NORMAL_MAX)
					r = RATE_NORM;
				else
					r = RATE_HIGH;
			end
			default:        r = RATE_NORM;
		endcase
		return r;
	endfunction : rate_for

	function automatic logic [15:0] interval_for(input slp_rate_e r);
		logic [15:0] n;
		n = 16'(CYC_REFI);
		case (r)
			RATE_LOW:  n = 16'(2 * CYC_REFI);
			RATE_HIGH: n = 16'(CYC_REFI / 2);
			default:   n = 16'(CYC_REFI);
		endcase
		return n;
	endfunction : interval_for

endpackage : slp_pkg

/* File: slp_sync.sv */
/*
 * Two flip-flop synchroniser for pin inputs.
 * Assumes each bit is a level that changes slowly relative to pclk.
 */
`timescale 1ns/1ps
module slp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= '0;
			q    <= '0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : slp_sync

/* File: slp_srf_engine.sv */
/*
 * Internal refresh timer used while in self-refresh.
 * Assumes active is high exactly while the device is in self-refresh.
 */
`timescale 1ns/1ps
module slp_srf_engine (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// control
	input  wire logic              active,
	input  wire logic              abort_en,
	input  wire slp_pkg::slp_rate_e rate,
	// status
	output logic                   refreshing,
	output logic [15:0]            ref_count
);
	logic [15:0] ivl;
	logic [15:0] next_ivl;
	logic [15:0] rfc;
	logic [15:0] next_rfc;
	logic        next_refreshing;
	logic [15:0] next_ref_count;

	always_comb
	begin
		next_ivl        = ivl;
		next_rfc        = rfc;
		next_refreshing = refreshing;
		next_ref_count  = ref_count;
		if (refreshing)
		begin
			if (!active && abort_en)
				next_refreshing = 1'b0;
			else if (rfc == 16'h0001)
			begin
				next_refreshing = 1'b0;
				next_ref_count  = ref_count + 16'h0001;
			end
			else
				next_rfc = rfc - 16'h0001;
		end
		if (!active)
			next_ivl = 16'h0000;
		else if (!refreshing || next_refreshing == 1'b0)
		begin
			if (ivl >= slp_pkg::interval_for(rate))
			begin
				next_ivl        = 16'h0000;
				next_refreshing = 1'b1;
				next_rfc        = 16'(slp_pkg::CYC_RFC);
			end
			else
				next_ivl = ivl + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ivl        <= 16'h0000;
			rfc        <= 16'h0000;
			refreshing <= 1'b0;
			ref_count  <= 16'h0000;
		end
		else
		begin
			ivl        <= next_ivl;
			rfc        <= next_rfc;
			refreshing <= next_refreshing;
			ref_count  <= next_ref_count;
		end
	end
endmodule : slp_srf_engine

/* File: slp_lowpower.sv */
/*
 * Low-power state control of a synchronous DRAM: self-refresh entry, exit and
 * abort, self-refresh rate selection, precharge and active power-down.
 * Assumes command pins and the temperature code arrive asynchronously and are
 * synchronised here; bank_open and core_busy come from pclk-domain core logic.
 */
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps

module slp_lowpower (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// dram pins
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        act_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic        dram_reset_n,
	input  wire logic [7:0]  temp_c,
	// core status
	input  wire logic        bank_open,
	input  wire logic        core_busy,
	// buffer and power control
	output logic             cmd_rcv_en,
	output logic             io_buf_en,
	output logic             odt_buf_en,
	output logic             rtt_nom_allow,
	output logic             rtt_park_en,
	output logic             dll_en,
	output logic             self_refresh,
	output logic             refreshing
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [6:0]  pins_s;
	logic [7:0]  temp_s;
	logic        cke_s;
	logic        cs_n_s;
	logic        act_n_s;
	logic        ras_n_s;
	logic        cas_n_s;
	logic        we_n_s;
	logic        rst_n_s;

	slp_sync #(.W(7)) u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({cke, cs_n, act_n, ras_n, cas_n, we_n, dram_reset_n}),
		.q       (pins_s)
	);

	slp_sync #(.W(8)) u_temp_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (temp_c),
		.q       (temp_s)
	);

	assign {cke_s, cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s, rst_n_s} = pins_s;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic cke_q;
	logic is_des;
	logic is_nop;
	logic is_sre;
	logic cke_fall;

	assign is_des   = cs_n_s;
	assign is_nop   = !cs_n_s && act_n_s && ras_n_s && cas_n_s && we_n_s;
	assign cke_fall = cke_q && !cke_s;
	assign is_sre   = cke_fall && !cs_n_s && !ras_n_s && !cas_n_s && we_n_s && act_n_s;

	// ----------------------------------------
	// control register
	// ----------------------------------------
	logic [4:0]  ctrl;
	logic [4:0]  next_ctrl;
	logic        abort_en;
	logic [1:0]  lpasr;
	logic        odt_off;
	logic        park_cfg;
	logic        wr_en;
	logic        mapped;
	logic [31:0] next_prdata;
	logic [15:0] ref_count;
	slp_pkg::slp_rate_e rate;

	assign abort_en = ctrl[slp_pkg::CTRL_ABORT_BIT];
	assign lpasr    = ctrl[slp_pkg::CTRL_LPASR_LSB +: 2];
	assign odt_off  = ctrl[slp_pkg::CTRL_ODTOFF_BIT];
	assign park_cfg = ctrl[slp_pkg::CTRL_PARK_BIT];

	assign rate     = slp_pkg::rate_for(lpasr, temp_s);

	assign mapped   = (paddr == slp_pkg::ADDR_CTRL) || (paddr == slp_pkg::ADDR_STATUS)
	                  || (paddr == slp_pkg::ADDR_REFCNT);
	assign wr_en    = psel && penable && pwrite && (paddr == slp_pkg::ADDR_CTRL);
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !mapped;

	// ----------------------------------------
	// state machine
	// ----------------------------------------
	slp_pkg::slp_state_e state;
	slp_pkg::slp_state_e next_state;
	logic [7:0]  cpded_cnt;
	logic [7:0]  next_cpded_cnt;
	logic        in_pd;
	logic        next_cmd_rcv_en;
	logic        next_io_buf_en;
	logic        next_odt_buf_en;
	logic        next_rtt_nom_allow;
	logic        next_rtt_park_en;
	logic        next_dll_en;
	logic        next_self_refresh;

	always_comb
	begin
		next_state = state;
		case (state)
			slp_pkg::ST_RESET:
			begin
				if (rst_n_s)
					next_state = slp_pkg::ST_IDLE;
			end
			slp_pkg::ST_IDLE:
			begin
				if (is_sre)
					next_state = slp_pkg::ST_SELF_REF;
				// entry on CKE low with deselect
				else if (cke_fall && is_des)
				begin
					if (core_busy)
						next_state = slp_pkg::ST_PD_SETTLE;
					else if (bank_open)
						next_state = slp_pkg::ST_PD_ACT;
					else
						next_state = slp_pkg::ST_PD_PRE;
				end
			end
			slp_pkg::ST_SELF_REF:
			begin
				// exit on CKE high with deselect or NOP
				if (cke_s && (is_des || is_nop))
					next_state = slp_pkg::ST_IDLE;
			end
			slp_pkg::ST_PD_SETTLE:
			begin
				// exit on CKE high with deselect
				if (cke_s && is_des)
					next_state = slp_pkg::ST_IDLE;
				else if (!core_busy)
					next_state = bank_open ? slp_pkg::ST_PD_ACT : slp_pkg::ST_PD_PRE;
			end
			slp_pkg::ST_PD_PRE,
			slp_pkg::ST_PD_ACT:
			begin
				// exit on CKE high with deselect
				if (cke_s && is_des)
					next_state = slp_pkg::ST_IDLE;
			end
			default:
				next_state = slp_pkg::ST_IDLE;
		endcase
		if (!rst_n_s)
			next_state = slp_pkg::ST_RESET;
	end

	assign in_pd = (next_state == slp_pkg::ST_PD_SETTLE) || (next_state == slp_pkg::ST_PD_PRE)
	               || (next_state == slp_pkg::ST_PD_ACT);

	always_comb
	begin
		next_cpded_cnt = 8'h00;
		if (in_pd)
			next_cpded_cnt = (cpded_cnt < 8'(slp_pkg::CYC_CPDED)) ? cpded_cnt + 8'h01 : cpded_cnt;
		next_self_refresh  = (next_state == slp_pkg::ST_SELF_REF);
		next_cmd_rcv_en    = !next_self_refresh && !(in_pd && next_cpded_cnt >= 8'(slp_pkg::CYC_CPDED));
		next_io_buf_en     = !in_pd && !next_self_refresh;
		next_odt_buf_en    = !next_self_refresh && !(in_pd && odt_off);
		next_rtt_nom_allow = !next_self_refresh && !(in_pd && odt_off);
		next_rtt_park_en   = park_cfg && !next_self_refresh;
		next_dll_en        = (next_state != slp_pkg::ST_SELF_REF) && (next_state != slp_pkg::ST_RESET);
	end

	always_comb
	begin
		next_ctrl = ctrl;
		if (wr_en)
			next_ctrl = pwdata[4:0];
		next_prdata = prdata;
		if (psel && !penable)
		begin
			case (paddr)
				slp_pkg::ADDR_CTRL:   next_prdata = {27'h000_0000, ctrl};
				slp_pkg::ADDR_STATUS: next_prdata = {26'h000_0000, refreshing, 2'(rate), 3'(state)};
				slp_pkg::ADDR_REFCNT: next_prdata = {16'h0000, ref_count};
				default:              next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state         <= slp_pkg::ST_RESET;
			cke_q         <= 1'b0;
			cpded_cnt     <= 8'h00;
			ctrl          <= slp_pkg::CTRL_RESET;
			prdata        <= 32'h0000_0000;
			cmd_rcv_en    <= 1'b1;
			io_buf_en     <= 1'b1;
			odt_buf_en    <= 1'b1;
			rtt_nom_allow <= 1'b1;
			rtt_park_en   <= 1'b0;
			dll_en        <= 1'b0;
			self_refresh  <= 1'b0;
		end
		else
		begin
			state         <= next_state;
			cke_q         <= cke_s;
			cpded_cnt     <= next_cpded_cnt;
			ctrl          <= next_ctrl;
			prdata        <= next_prdata;
			cmd_rcv_en    <= next_cmd_rcv_en;
			io_buf_en     <= next_io_buf_en;
			odt_buf_en    <= next_odt_buf_en;
			rtt_nom_allow <= next_rtt_nom_allow;
			rtt_park_en   <= next_rtt_park_en;
			dll_en        <= next_dll_en;
			self_refresh  <= next_self_refresh;
		end
	end

	// ----------------------------------------
	// self-refresh engine
	// ----------------------------------------
	// abort steered by control bit
	slp_srf_engine u_srf (
		.pclk       (pclk),
		.presetn    (presetn),
		.active     (state == slp_pkg::ST_SELF_REF),
		.abort_en   (abort_en),
		.rate       (rate),
		.refreshing (refreshing),
		.ref_count  (ref_count)
	);

endmodule : slp_lowpower

/* File: slp_lowpower_checker.sv */
/*
 * Concurrent checks on the pin-side behaviour of slp_lowpower.
 * Assumes it is bound to slp_lowpower and sees only its ports.
 */
`timescale 1ns/1ps
module slp_lowpower_checker (
	// clock and apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	// pins and core status
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        act_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        dram_reset_n,
	input wire logic        core_busy,
	// status outputs
	input wire logic        cmd_rcv_en,
	input wire logic        io_buf_en,
	input wire logic        odt_buf_en,
	input wire logic        rtt_nom_allow,
	input wire logic        dll_en,
	input wire logic        self_refresh,
	input wire logic        refreshing
);
	logic [4:0] ctrl;
	logic [4:0] next_ctrl;
	logic       idle;
	logic       pd;
	logic       quiet;

	// mirror of the control register
	always_comb
	begin
		next_ctrl = ctrl;
		if (psel && penable && pwrite && paddr == slp_pkg::ADDR_CTRL)
			next_ctrl = pwdata[4:0];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= slp_pkg::CTRL_RESET;
		else
			ctrl <= next_ctrl;
	end
	assign idle  = dll_en && io_buf_en && !self_refresh && dram_reset_n;
	assign pd    = !io_buf_en && !self_refresh;
	assign quiet = cs_n || (act_n && ras_n && cas_n && we_n);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_sre_entry: assert property (
		$fell(cke) && !cs_n && !ras_n && !cas_n && we_n && act_n && idle |-> ##[1:3] self_refresh)
		else $error("self-refresh entry missed");
	a_pd_entry: assert property (
		$fell(cke) && cs_n && idle && !core_busy |-> ##[1:3] pd)
		else $error("power-down entry missed");
	a_pd_dll: assert property (pd |-> dll_en)
		else $error("dll off in power-down");
	a_cpded_hold: assert property (
		$fell(io_buf_en) && !self_refresh && !core_busy |-> cmd_rcv_en [*3] ##[1:2] !cmd_rcv_en)
		else $error("command receivers off at wrong time");
	a_odt_pd: assert property (
		pd && !core_busy |-> odt_buf_en == !ctrl[slp_pkg::CTRL_ODTOFF_BIT] && rtt_nom_allow == odt_buf_en)
		else $error("odt buffer wrong in power-down");
	a_pd_exit: assert property (
		pd && $rose(cke) && cs_n |-> ##[1:3] io_buf_en && cmd_rcv_en && odt_buf_en)
		else $error("power-down exit missed");
	a_sr_exit: assert property (
		self_refresh && $rose(cke) && quiet |-> ##[1:3] !self_refresh && dll_en)
		else $error("self-refresh exit missed");
	a_abort_stop: assert property (
		self_refresh && refreshing && ctrl[slp_pkg::CTRL_ABORT_BIT] && $rose(cke) |-> ##[1:4] !refreshing)
		else $error("refresh not aborted on exit");
	a_reset_pin: assert property (
		!dram_reset_n [*4] |-> !dll_en && !self_refresh && io_buf_en)
		else $error("pin reset not honoured");
endmodule : slp_lowpower_checker

/* File: slp_host_model.sv */
/*
 * Behavioural memory controller driving the DRAM command pins.
 * Assumes pclk stands for CK; tasks are called just after a rising edge.
 */
`timescale 1ns/1ps
module slp_host_model #(
	parameter int T_CKE     = 6,
	parameter int T_XP      = 6,
	parameter int T_XS_ABRT = 8
) (
	// clock
	input  wire logic pclk,
	// pins
	output logic      cke,
	output logic      cs_n,
	output logic      act_n,
	output logic      ras_n,
	output logic      cas_n,
	output logic      we_n,
	output logic      dram_reset_n
);
	localparam logic [3:0] CMD_REF = 4'h9;
	localparam logic [3:0] CMD_NOP = 4'hF;
	logic       sel      = 1'b0;
	logic [3:0] cmd      = 4'hF;
	logic       tog      = 1'b0;
	logic       need_ref = 1'b0;

	initial
	begin
		cke = 1'b1;
		dram_reset_n = 1'b1;
	end
	// deselected lines toggle so a stale value never looks valid
	always @(posedge pclk)
		tog <= !tog;
	assign cs_n = !sel;
	assign {act_n, ras_n, cas_n, we_n} = sel ? cmd : {4{tog}};

	task automatic issue(input logic s, input logic [3:0] c, input logic k, input int n);
		sel <= s;
		cmd <= c;
		cke <= k;
		repeat (n) @(posedge pclk);
	endtask : issue

	// deselect before and after the entry command
	task automatic sr_enter();
		if (need_ref)
		begin
			issue(1'b1, CMD_REF, 1'b1, 1);
			issue(1'b0, CMD_NOP, 1'b1, slp_pkg::CYC_RFC + 2);
		end
		need_ref = 1'b0;
		issue(1'b0, CMD_NOP, 1'b1, 1);
		issue(1'b1, CMD_REF, 1'b0, 1);
		issue(1'b0, CMD_NOP, 1'b0, T_CKE);
	endtask : sr_enter

	// exit wait chosen by abort, NOP or deselect chosen by nop
	task automatic sr_exit(input logic nop, input logic abort);
		issue(nop, CMD_NOP, 1'b1, nop ? 2 : 1);
		issue(1'b0, CMD_NOP, 1'b1, abort ? T_XS_ABRT : slp_pkg::CYC_RFC + 3);
		need_ref = 1'b1;
	endtask : sr_exit

	// deselect as cke falls, idle with dll locked
	task automatic pd_enter();
		issue(1'b0, CMD_NOP, 1'b0, T_CKE);
	endtask : pd_enter

	// cke high with deselect, then exit latency
	task automatic pd_exit();
		issue(1'b0, CMD_NOP, 1'b1, T_XP);
	endtask : pd_exit

	task automatic pin_reset(input logic v);
		dram_reset_n <= v;
		if (v)
			cke <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask : pin_reset
endmodule : slp_host_model

/* File: slp_lowpower_tb.sv */
/*
 * Self-checking bench for slp_lowpower: apb tasks, core status, host model.
 * Assumes slp_pkg offsets and the checker bound at the foot of this file.
 */
`timescale 1ns/1ps
module slp_lowpower_tb;
	logic        pclk      = 1'b0;
	logic        presetn   = 1'b0;
	logic [11:0] paddr     = 12'h000;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [31:0] pwdata    = 32'h0000_0000;
	logic [7:0]  temp_c    = 8'h19;
	logic        bank_open = 1'b0;
	logic        core_busy = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, cke, cs_n, act_n, ras_n, cas_n, we_n, dram_reset_n;
	logic        cmd_rcv_en, io_buf_en, odt_buf_en, rtt_nom_allow, rtt_park_en, dll_en, self_refresh, refreshing;
	int          miscompares  = 0;
	int          total_checks = 0;
	int          cycles       = 0;

	slp_lowpower i_slp_lowpower (.*);
	slp_host_model i_slp_host_model (.*);

	initial
	begin
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		check(what, exp, q & m);
	endtask : rd_chk

	task automatic t_regs();
		logic [31:0] q;
		logic        e;
		rd_chk("ctrl reset", slp_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk("refcnt reset", slp_pkg::ADDR_REFCNT, 32'h0000_FFFF, 32'h0000_0000);
		wr(slp_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
		rd_chk("ctrl width", slp_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_001F);
		wr(slp_pkg::ADDR_STATUS, 32'h0000_0000);
		rd_chk("status idle", slp_pkg::ADDR_STATUS, 32'h0000_0007, 32'h0000_0001);
		apb(1'b0, 12'h00C, 32'h0000_0000, q, e);
		check("unmapped", 32'h0000_0001, {q[30:0], e});
	endtask : t_regs

	task automatic t_rates();
		logic [1:0] md [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
		logic [7:0] tc [7] = '{8'h5A, 8'h5A, 8'h00, 8'h2D, 8'h2E, 8'h55, 8'h56};
		logic [1:0] rt [7] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2};
		for (int i = 0; i < 7; i++)
		begin
			temp_c <= tc[i];
			wr(slp_pkg::ADDR_CTRL, {29'h0, md[i], 1'b0});
			repeat (4) @(posedge pclk);
			rd_chk("rate", slp_pkg::ADDR_STATUS, 32'h0000_0018, {27'h0, rt[i], 3'h0});
		end
	endtask : t_rates

	task automatic t_sr(input logic abort, input logic nop, input logic [31:0] cnt);
		int i;
		wr(slp_pkg::ADDR_CTRL, {29'h0000_0002, slp_pkg::LPASR_EXTENDED, abort});
		i_slp_host_model.sr_enter();
		for (i = 0; i < 1000 && refreshing !== 1'b1; i++)
			@(posedge pclk);
		check("sr flags", 32'h0000_000C, {28'h0, refreshing, self_refresh, dll_en, rtt_park_en});
		i_slp_host_model.sr_exit(nop, abort);
		check("sr exit", 32'h0000_0001, {29'h0, refreshing, self_refresh, dll_en});
		rd_chk("refresh count", slp_pkg::ADDR_REFCNT, 32'h0000_FFFF, cnt);
	endtask : t_sr

	task automatic t_pd(input logic bank, input logic busy, input logic odtoff);
		logic [5:0] want;
		want = {3'h1, !odtoff, !odtoff, 1'b1};
		wr(slp_pkg::ADDR_CTRL, {28'h000_0001, odtoff, 3'h0});
		bank_open <= bank;
		core_busy <= busy;
		@(posedge pclk);
		i_slp_host_model.pd_enter();
		if (busy)
		begin
			rd_chk("settle", slp_pkg::ADDR_STATUS, 32'h0000_0007, 32'h0000_0003);
			core_busy <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		rd_chk("pd kind", slp_pkg::ADDR_STATUS, 32'h0000_0007, {29'h0, 2'h2, bank});
		check("pd enables", {26'h0, want}, {26'h0, io_buf_en, cmd_rcv_en, dll_en, odt_buf_en, rtt_nom_allow,
			rtt_park_en});
		i_slp_host_model.pd_exit();
		check("pd exit", 32'h0000_0007, {29'h0, io_buf_en, cmd_rcv_en, odt_buf_en});
	endtask : t_pd

	task automatic t_rst();
		i_slp_host_model.pd_enter();
		i_slp_host_model.pin_reset(1'b0);
		rd_chk("pin reset", slp_pkg::ADDR_STATUS, 32'h0000_0007, 32'h0000_0000);
		check("reset dll", 32'h0000_0000, {31'h0, dll_en});
		i_slp_host_model.pin_reset(1'b1);
		rd_chk("reset release", slp_pkg::ADDR_STATUS, 32'h0000_0007, 32'h0000_0001);
	endtask : t_rst

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_rates();
		t_sr(1'b1, 1'b0, 32'h0000_0000);
		t_sr(1'b0, 1'b1, 32'h0000_0001);
		t_pd(1'b0, 1'b0, 1'b1);
		t_pd(1'b1, 1'b0, 1'b0);
		t_pd(1'b1, 1'b1, 1'b0);
		t_rst();
		report_and_stop();
	end
endmodule : slp_lowpower_tb

bind slp_lowpower slp_lowpower_checker i_slp_lowpower_checker (.*);
